/* rtl/plfsk_fifo.sv */
// Synchronous FIFO with valid/ready on both sides, flip-flop storage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module plfsk_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic room_r, room_nxt;
    logic push, pop;

    // Room is registered so the ready seen by the source comes straight from a flop
    always_comb begin
        push = in_valid && room_r;
        pop = out_ready && (cnt_r != '0);
        wr_nxt = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
        room_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            room_r <= 1'b1;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            room_r <= room_nxt;
        end
    end

    // Storage is written only on a push; contents need no reset
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    assign in_ready = room_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
endmodule

/* rtl/plfsk_modem.sv */
// Digital half of a half-duplex FSK powerline modem: byte serializer with tone
// divider on transmit, bit sampler and deserializer on receive.
// Assumes the comparator output rx_bit is already synchronous to mclk.
//
// What this block does
// - Bytes from the network side are serialized one bit at a time.
// - Tone is the clock divided by one of two ratios picked by bit.
// - Zero bit gives about 133.3 kHz, one bit about 131.8 kHz.
// - Wide option moves the one-bit tone to 130.4 kHz; zero tone unchanged.
// - Bits run at 2400 per second both ways.
// - Never transmits and receives at the same time.
// - Comparator output at 2400 baud is taken as the received bit stream.
// - Received bits are packed into bytes and handed to the network side.
`timescale 1ns/1ps
module plfsk_modem #(
    parameter int unsigned BIT_CYCLES = plfsk_pkg::BIT_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic wide_dev,
    output logic tone_out,
    output logic tx_active,
    input wire logic rx_bit,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic rx_active
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_BIT_LAST = 16'(BIT_CYCLES / 2 - 1);

    logic [7:0] f_data;
    logic f_valid, f_pop, tx_start;

    // Eight-byte buffer; stalls the network side when the line is slow
    plfsk_fifo #(.WIDTH(plfsk_pkg::DATA_W), .DEPTH(plfsk_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    plfsk_pkg::plfsk_tx_state_type tx_st_r, tx_st_nxt;
    logic [15:0] tx_tmr_r, tx_tmr_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [2:0] tx_cnt_r, tx_cnt_nxt;
    logic txbit_r, txbit_nxt;
    logic [7:0] tone_cnt_r, tone_cnt_nxt, half_sel;
    logic tone_r, tone_nxt, tx_act_r, tx_act_nxt;

    plfsk_pkg::plfsk_rx_state_type rx_st_r, rx_st_nxt;
    logic [15:0] rx_tmr_r, rx_tmr_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt, rx_data_r, rx_data_nxt;
    logic [2:0] rx_cnt_r, rx_cnt_nxt;
    logic rx_prev_r, rx_valid_r, rx_valid_nxt, rx_ovr_r, rx_ovr_nxt;
    logic rx_act_r, rx_act_nxt;

    // Divider ratio follows the bit on the line; wide option only hits ones
    always_comb begin
        if (!txbit_r) begin
            half_sel = plfsk_pkg::HALF0;
        end else if (wide_dev) begin
            half_sel = plfsk_pkg::HALF1W;
        end else begin
            half_sel = plfsk_pkg::HALF1;
        end
    end

    // Transmit sequencer and tone generator
    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_tmr_nxt = tx_tmr_r;
        tx_sh_nxt = tx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        txbit_nxt = txbit_r;
        tone_cnt_nxt = tone_cnt_r;
        tone_nxt = tone_r;
        // Transmit only starts while the receiver is idle
        tx_start = (tx_st_r == plfsk_pkg::TX_IDLE) && f_valid
            && (rx_st_r == plfsk_pkg::RX_IDLE);
        f_pop = tx_start;
        if (tx_st_r == plfsk_pkg::TX_IDLE) begin
            tone_nxt = 1'b0;
            txbit_nxt = plfsk_pkg::LINE_IDLE;
            if (tx_start) begin
                tx_sh_nxt = f_data;
                tx_st_nxt = plfsk_pkg::TX_START;
                tx_tmr_nxt = BIT_LAST;
                txbit_nxt = 1'b0;
                tone_cnt_nxt = plfsk_pkg::HALF0 - 8'h01; // First half as long as the rest
            end
        end else begin
            // Tone half-period count: divide mclk by the bit's ratio
            if (tone_cnt_r == 8'h00) begin
                tone_nxt = !tone_r;
                tone_cnt_nxt = half_sel - 8'h01;
            end else begin
                tone_cnt_nxt = tone_cnt_r - 8'h01;
            end
            if (tx_tmr_r != 16'h0000) begin
                tx_tmr_nxt = tx_tmr_r - 16'h0001;
            end else begin
                tx_tmr_nxt = BIT_LAST;
                case (tx_st_r)
                    plfsk_pkg::TX_START: begin
                        tx_st_nxt = plfsk_pkg::TX_DATA;
                        tx_cnt_nxt = 3'h0;
                        txbit_nxt = tx_sh_r[0];
                        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                    end
                    plfsk_pkg::TX_DATA: begin
                        if (tx_cnt_r == plfsk_pkg::LAST_BIT) begin
                            tx_st_nxt = plfsk_pkg::TX_STOP;
                            txbit_nxt = 1'b1;
                        end else begin
                            tx_cnt_nxt = tx_cnt_r + 3'h1;
                            txbit_nxt = tx_sh_r[0];
                            tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                        end
                    end
                    plfsk_pkg::TX_STOP: begin
                        tx_st_nxt = plfsk_pkg::TX_IDLE;
                        txbit_nxt = plfsk_pkg::LINE_IDLE;
                        tone_nxt = 1'b0;
                    end
                    default: tx_st_nxt = plfsk_pkg::TX_IDLE;
                endcase
            end
        end
        tx_act_nxt = (tx_st_nxt != plfsk_pkg::TX_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_st_r <= plfsk_pkg::TX_IDLE;
            tx_tmr_r <= 16'h0000;
            tx_sh_r <= 8'h00;
            tx_cnt_r <= 3'h0;
            txbit_r <= plfsk_pkg::LINE_IDLE;
            tone_cnt_r <= 8'h00;
            tone_r <= 1'b0;
            tx_act_r <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            tx_tmr_r <= tx_tmr_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            txbit_r <= txbit_nxt;
            tone_cnt_r <= tone_cnt_nxt;
            tone_r <= tone_nxt;
            tx_act_r <= tx_act_nxt;
        end
    end

    // Receive sampler: start edge, mid-bit check, then one sample per bit
    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_tmr_nxt = rx_tmr_r;
        rx_sh_nxt = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_data_nxt = rx_data_r;
        rx_ovr_nxt = 1'b0;
        // Consumer clears valid; a new byte in the same cycle still lands
        rx_valid_nxt = rx_valid_r && !rx_ready;
        case (rx_st_r)
            plfsk_pkg::RX_IDLE: begin
                // Transmit has priority and blanks the receiver
                if (rx_prev_r && !rx_bit && !tx_act_r && !tx_start) begin
                    rx_st_nxt = plfsk_pkg::RX_START;
                    rx_tmr_nxt = HALF_BIT_LAST;
                end
            end
            plfsk_pkg::RX_START: begin
                if (rx_tmr_r != 16'h0000) begin
                    rx_tmr_nxt = rx_tmr_r - 16'h0001;
                end else if (!rx_bit) begin
                    rx_st_nxt = plfsk_pkg::RX_DATA;
                    rx_tmr_nxt = BIT_LAST;
                    rx_cnt_nxt = 3'h0;
                end else begin
                    rx_st_nxt = plfsk_pkg::RX_IDLE; // Glitch, not a start bit
                end
            end
            plfsk_pkg::RX_DATA: begin
                if (rx_tmr_r != 16'h0000) begin
                    rx_tmr_nxt = rx_tmr_r - 16'h0001;
                end else begin
                    rx_sh_nxt = {rx_bit, rx_sh_r[7:1]};
                    rx_tmr_nxt = BIT_LAST;
                    rx_cnt_nxt = rx_cnt_r + 3'h1;
                    if (rx_cnt_r == plfsk_pkg::LAST_BIT) begin
                        rx_st_nxt = plfsk_pkg::RX_STOP;
                    end
                end
            end
            plfsk_pkg::RX_STOP: begin
                if (rx_tmr_r != 16'h0000) begin
                    rx_tmr_nxt = rx_tmr_r - 16'h0001;
                end else begin
                    rx_st_nxt = plfsk_pkg::RX_IDLE;
                    // Bad stop bit drops the byte silently
                    if (rx_bit) begin
                        if (rx_valid_r && !rx_ready) begin
                            rx_ovr_nxt = 1'b1; // Old byte kept, new one lost
                        end else begin
                            rx_data_nxt = rx_sh_r;
                            rx_valid_nxt = 1'b1;
                        end
                    end
                end
            end
            default: rx_st_nxt = plfsk_pkg::RX_IDLE;
        endcase
        rx_act_nxt = (rx_st_nxt != plfsk_pkg::RX_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_st_r <= plfsk_pkg::RX_IDLE;
            rx_tmr_r <= 16'h0000;
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_data_r <= 8'h00;
            rx_prev_r <= plfsk_pkg::LINE_IDLE;
            rx_valid_r <= 1'b0;
            rx_ovr_r <= 1'b0;
            rx_act_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            rx_tmr_r <= rx_tmr_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_data_r <= rx_data_nxt;
            rx_prev_r <= rx_bit;
            rx_valid_r <= rx_valid_nxt;
            rx_ovr_r <= rx_ovr_nxt;
            rx_act_r <= rx_act_nxt;
        end
    end

    assign tone_out = tone_r;
    assign tx_active = tx_act_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;
    assign rx_overrun = rx_ovr_r;
    assign rx_active = rx_act_r;

    // Checks on the sequencers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_HALF_DUPLEX: assert property (!(tx_act_r && rx_act_r))
        else $error("Transmit and receive active together");
    AST_POP_START: assert property (f_pop |=> tx_st_r == plfsk_pkg::TX_START
        && !txbit_r && tx_tmr_r == BIT_LAST)
        else $error("Buffer pop did not start a frame");
    AST_TONE_TOGGLE: assert property ((tx_st_r != plfsk_pkg::TX_IDLE
        && tone_cnt_r == 8'h00 && tx_tmr_r != 16'h0000) |=> $changed(tone_r))
        else $error("Tone did not toggle at end of half period");
    AST_TONE_ZERO: assert property ((tx_tmr_r != 16'h0000 && tone_cnt_r == 8'h00
        && tx_st_r != plfsk_pkg::TX_IDLE && !txbit_r)
        |=> tone_cnt_r == plfsk_pkg::HALF0 - 8'h01)
        else $error("Zero-bit tone period wrong");
    AST_TONE_WIDE: assert property ((tx_tmr_r != 16'h0000 && tone_cnt_r == 8'h00
        && tx_st_r != plfsk_pkg::TX_IDLE && txbit_r && wide_dev)
        |=> tone_cnt_r == plfsk_pkg::HALF1W - 8'h01)
        else $error("Wide one-bit tone period wrong");
    AST_BIT_STABLE: assert property ((tx_st_r != plfsk_pkg::TX_IDLE
        && tx_tmr_r != 16'h0000) |=> $stable(txbit_r))
        else $error("Line bit changed inside a bit period");
    AST_RX_MID: assert property ((rx_st_r == plfsk_pkg::RX_START
        && rx_tmr_r == 16'h0000 && !rx_bit)
        |=> rx_st_r == plfsk_pkg::RX_DATA && rx_tmr_r == BIT_LAST)
        else $error("Receiver not aligned to bit centre");
    AST_RX_SAMPLE: assert property ((rx_st_r == plfsk_pkg::RX_DATA
        && rx_tmr_r == 16'h0000) |=> rx_sh_r[7] == $past(rx_bit))
        else $error("Received bit not sampled");
    AST_RX_DELIVER: assert property ((rx_st_r == plfsk_pkg::RX_STOP
        && rx_tmr_r == 16'h0000 && rx_bit && !(rx_valid_r && !rx_ready))
        |=> rx_valid_r && rx_data_r == $past(rx_sh_r))
        else $error("Received byte not delivered");
    AST_IDLE_QUIET: assert property (!tx_act_r |-> !tone_r)
        else $error("Tone running while idle");

    COV_TX_FRAME: cover property (tx_st_r == plfsk_pkg::TX_STOP ##1 !tx_act_r);
    COV_RX_BYTE: cover property (rx_st_r == plfsk_pkg::RX_STOP ##1 rx_valid_r);
    COV_WIDE_ONE: cover property (tx_act_r && txbit_r && wide_dev);
    COV_OVERRUN: cover property (rx_ovr_r);
endmodule

/* rtl/plfsk_pkg.sv */
// Constants, timing counts and state types of the powerline FSK modem.
// Assumes a single 50 MHz system clock that all counts are derived from.
package plfsk_pkg;
    // System clock rate
    localparam int unsigned CLK_HZ = 50_000_000;
    // Raw line bit rate
    localparam int unsigned BAUD_BPS = 2400;
    // Bit period in clock cycles, rounded down
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
    // Tone frequencies: zero bit, one bit, one bit with wide deviation
    localparam int unsigned TONE0_HZ = 133_300;
    localparam int unsigned TONE1_HZ = 131_800;
    localparam int unsigned TONE1W_HZ = 130_400;
    // Half-period counts of each tone, rounded down
    localparam logic [7:0] HALF0 = 8'(CLK_HZ / (2 * TONE0_HZ));
    localparam logic [7:0] HALF1 = 8'(CLK_HZ / (2 * TONE1_HZ));
    localparam logic [7:0] HALF1W = 8'(CLK_HZ / (2 * TONE1W_HZ));
    // Word and buffer shape
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Line idles high; a frame is start 0, eight data bits LSB first, stop 1
    localparam logic LINE_IDLE = 1'h1;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } plfsk_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } plfsk_rx_state_type;
endpackage

/* tb/plfsk_line_model.sv */
// Far-side model: analog front end seen from the modem's digital pins.
// Measures tone half periods and plays framed bit streams on the comparator line.
// Assumes the caller may start a frame at any time; it begins on the next rising edge.
`timescale 1ns/1ps
module plfsk_line_model #(
    parameter int unsigned BIT_CYCLES = 40
) (
    input wire logic mclk,
    input wire logic tone_out,
    output logic rx_bit
);
    int unsigned run_len = 0;
    int unsigned last_half = 0;
    logic tone_q = 1'h0;

    // Comparator output rests high between frames
    initial begin
        rx_bit = 1'h1;
    end

    // Length of the last complete tone half period, in clock cycles
    always @(posedge mclk) begin
        tone_q <= tone_out;
        if (tone_out !== tone_q) begin
            last_half <= run_len;
            run_len <= 1;
        end else begin
            run_len <= run_len + 1;
        end
    end

    // One frame: low start, eight bits LSB first, stop bit as given
    // No trailing idle; back-to-back frames just see one extra stop cycle
    task automatic send_frame(input logic [7:0] b, input logic stop_ok);
        logic [9:0] f;
        f = {stop_ok, b, 1'h0};
        @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            rx_bit <= f[i];
            repeat (BIT_CYCLES) @(posedge mclk);
        end
    endtask

    // A short low pulse that must not be taken for a start bit
    task automatic glitch(input int unsigned n);
        @(posedge mclk);
        rx_bit <= 1'h0;
        repeat (n) @(posedge mclk);
        rx_bit <= 1'h1;
    endtask

    // Return the line to its idle level for a while
    task automatic line_idle(input int unsigned n);
        rx_bit <= 1'h1;
        repeat (n) @(posedge mclk);
    endtask
endmodule

/* tb/tb_powerline_fsk_modem_digital.sv */
// Self-checking bench for the FSK modem digital half.
// Assumes the shortened bit period below; bit timing derives from it, tone half periods from plfsk_pkg.
`timescale 1ns/1ps
module tb_powerline_fsk_modem_digital;
    localparam int unsigned BITC = 400;
    localparam int unsigned H0 = plfsk_pkg::CLK_HZ / (2 * plfsk_pkg::TONE0_HZ);
    localparam int unsigned H1 = plfsk_pkg::CLK_HZ / (2 * plfsk_pkg::TONE1_HZ);
    localparam int unsigned H1W = plfsk_pkg::CLK_HZ / (2 * plfsk_pkg::TONE1W_HZ);
    localparam int unsigned TIMEOUT = 90000;

    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'h0;
    logic tx_ready;
    logic wide_dev = 1'h0;
    logic tone_out;
    logic tx_active;
    logic rx_bit;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_ready = 1'h0;
    logic rx_overrun;
    logic rx_active;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int tx_starts = 0;
    logic act_q = 1'h0;
    logic ovr_seen = 1'h0;
    logic dup_seen = 1'h0;

    // 50 MHz clock
    always #10 mclk = ~mclk;

    plfsk_modem #(.BIT_CYCLES(BITC)) dut (.mclk(mclk), .srst(srst), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .wide_dev(wide_dev), .tone_out(tone_out),
        .tx_active(tx_active), .rx_bit(rx_bit), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .rx_active(rx_active));

    plfsk_line_model #(.BIT_CYCLES(BITC)) line (.mclk(mclk), .tone_out(tone_out),
        .rx_bit(rx_bit));

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Advance n cycles and let the last edge's updates settle
    task automatic tick(input int unsigned n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Sticky watchers and the hang limit; a pulse is caught whenever it happens
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        act_q <= tx_active;
        if (rx_overrun === 1'h1) begin
            ovr_seen <= 1'h1;
        end
        if (rx_active === 1'h1 && tx_active === 1'h1) begin
            dup_seen <= 1'h1;
        end
        if (tx_active === 1'h1 && act_q !== 1'h1) begin
            tx_starts <= tx_starts + 1;
        end
        if (cycles == TIMEOUT) begin
            mismatches++;
            results();
        end
    end

    // One byte out: decode the tone length near the end of every bit period
    task automatic tx_frame(input logic [7:0] b, input logic wide);
        logic [9:0] f;
        int n;
        f = {1'h1, b, 1'h0};
        n = 0;
        @(posedge mclk);
        wide_dev <= wide;
        tx_data <= b;
        tx_valid <= 1'h1;
        @(posedge mclk);
        tx_valid <= 1'h0;
        #1;
        while (tx_active !== 1'h1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(16'(tx_active), 16'h0001);
        for (int i = 0; i < 10; i++) begin
            tick(BITC - 5);
            chk(16'(line.last_half), 16'(f[i] ? (wide ? H1W : H1) : H0));
            tick(5);
        end
        tick(2);
        chk({14'h0, tx_active, tone_out}, 16'h0000);
    endtask

    // Two frames back to back unread, a broken stop bit, then a clean frame
    task automatic rx_frames();
        line.send_frame(8'h5a, 1'h1);
        tick(0);
        chk({7'h0, rx_valid, rx_data}, 16'h015a);
        line.send_frame(8'h96, 1'h1);
        tick(2);
        chk({7'h0, ovr_seen, rx_data}, 16'h015a);
        @(posedge mclk);
        rx_ready <= 1'h1;
        @(posedge mclk);
        rx_ready <= 1'h0;
        tick(2);
        chk(16'(rx_valid), 16'h0000);
        line.send_frame(8'h33, 1'h0);
        line.line_idle(2 * BITC);
        chk(16'(rx_valid), 16'h0000);
        line.glitch(20);
        tick(BITC);
        chk({14'h0, rx_active, rx_valid}, 16'h0000);
        line.send_frame(8'hc3, 1'h1);
        tick(0);
        chk({7'h0, rx_valid, rx_data}, 16'h01c3);
        @(posedge mclk);
        rx_ready <= 1'h1;
        @(posedge mclk);
        rx_ready <= 1'h0;
    endtask

    // Line activity during a transmission must not start a reception
    task automatic half_duplex();
        @(posedge mclk);
        tx_data <= 8'h00;
        tx_valid <= 1'h1;
        @(posedge mclk);
        tx_valid <= 1'h0;
        repeat (2 * BITC) @(posedge mclk);
        line.send_frame(8'hff, 1'h1);
        line.line_idle(4 * BITC);
        chk({14'h0, dup_seen, rx_valid}, 16'h0000);
        // A byte queued during a reception waits until the receiver is done
        fork
            line.send_frame(8'h81, 1'h1);
            begin
                repeat (BITC) @(posedge mclk);
                tx_valid <= 1'h1;
                @(posedge mclk);
                tx_valid <= 1'h0;
            end
        join
        tick(0);
        chk({6'h0, tx_active, dup_seen, rx_data}, 16'h0281);
        @(posedge mclk);
        rx_ready <= 1'h1;
        @(posedge mclk);
        rx_ready <= 1'h0;
        tick(10 * BITC + 10);
        chk({14'h0, dup_seen, tx_active}, 16'h0000);
    endtask

    // Fill the transmit buffer until refused, then let it drain completely
    task automatic fill_drain();
        int acc;
        int base;
        acc = 0;
        base = tx_starts;
        @(posedge mclk);
        tx_valid <= 1'h1;
        tx_data <= 8'h10;
        for (int k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (tx_ready === 1'h1) begin
                acc++;
                tx_data <= tx_data + 8'h01;
            end
        end
        tx_valid <= 1'h0;
        // The first byte leaves the buffer at once, so one more fits
        chk(16'(acc), 16'(plfsk_pkg::FIFO_DEPTH + 1));
        tick(1);
        for (int k = 0; k < 10 * BITC * 9 + 500 && tx_starts - base < 9; k++) begin
            tick(1);
        end
        tick(10 * BITC + 10);
        chk({14'h0, tx_ready, tx_active}, 16'h0002);
        chk(16'(tx_starts - base), 16'h0009);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'h0;
        tick(2);
        chk({13'h0, tx_ready, tone_out, rx_valid}, 16'h0004);
        tx_frame(8'ha5, 1'h0);
        tx_frame(8'h3c, 1'h1);
        rx_frames();
        half_duplex();
        fill_drain();
        results();
    end
endmodule
